// ### dlr_pkg.sv
// dlr_pkg: constants for the defect list reader.
// assumes a byte-wide read data stream from the sector data field, one byte per valid strobe.
//
// Operation
// - primary list at cylinder 1223 sector 0, backup copy at cylinder 1215 sector 0.
// - each surface's sector zero holds only that surface's defect entries.
// - data field is 256 bytes followed by two CRC bytes, x^16+x^12+x^5+1.
// - entries are fixed five-byte fields, stepped through in fives.
// - each entry gives head, track (cylinder) and byte offset.
// - byte offset counts bytes from the track index mark.
// - cylinder zero is defect-free, never listed.
// - at most fifty defects per surface on average; storage sized for it.
package dlr_pkg;
    localparam logic [10:0] DLR_PRIMARY_CYL  = 11'd1223;
    localparam logic [10:0] DLR_BACKUP_CYL   = 11'd1215;
    localparam logic [8:0]  DLR_FIELD_BYTES  = 9'd256;
    localparam logic [2:0]  DLR_ENTRY_BYTES  = 3'd5;
    localparam logic [15:0] DLR_CRC_POLY     = 16'h1021;
    localparam logic [15:0] DLR_CRC_PRESET   = 16'hffff;
    localparam int          DLR_MAX_ENTRIES  = 50;
    localparam logic [5:0]  DLR_MAX_IDX      = 6'd50;
    localparam logic [7:0]  DLR_END_BYTE     = 8'hff;
    localparam logic [15:0] DLR_OFFSET_SLACK = 16'h0001;
endpackage

// ### dlr_crc16.sv
// dlr_crc16: byte-serial CRC-16 update for the defect record.
// assumes one byte per enabled clock, msb first.
`timescale 1ns/100ps
module dlr_crc16 (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        clr,
    input  wire logic        en,
    input  wire logic [7:0]  din,
    output logic      [15:0] crc
);
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;

    always_comb begin
        crc_nxt = crc_r;
        for (int i = 7; i >= 0; i--) begin
            if (crc_nxt[15] ^ din[i]) begin
                crc_nxt = {crc_nxt[14:0], 1'b0} ^ dlr_pkg::DLR_CRC_POLY;
            end else begin
                crc_nxt = {crc_nxt[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            crc_r <= dlr_pkg::DLR_CRC_PRESET;
        end else if (clr) begin
            crc_r <= dlr_pkg::DLR_CRC_PRESET;
        end else if (en) begin
            crc_r <= crc_nxt;
        end
    end

    assign crc = crc_r;
endmodule

// ### dlr_reader.sv
// dlr_reader: walks one defect record sector, decodes entries, checks CRC.
// assumes sector_start pulses before the first data byte; bytes arrive as byte_valid pulses.
`timescale 1ns/100ps
module dlr_reader (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        sector_start,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    input  wire logic [10:0] cur_cyl,
    input  wire logic [3:0]  cur_head,
    input  wire logic        use_backup,
    input  wire logic [5:0]  rd_idx,
    output logic             target_ok,
    output logic             entry_valid,
    output logic      [10:0] entry_cyl,
    output logic      [3:0]  entry_head,
    output logic      [15:0] entry_offset,
    output logic      [15:0] entry_lo,
    output logic      [15:0] entry_hi,
    output logic             entry_bad,
    output logic             list_end,
    output logic             crc_done,
    output logic             crc_error,
    output logic      [5:0]  entry_count,
    output logic             overflow,
    output logic      [10:0] rd_cyl,
    output logic      [3:0]  rd_head,
    output logic      [15:0] rd_offset
);
    // ****************************************
    // states
    // ****************************************
    typedef enum logic [3:0] {
        DLR_IDLE = 4'b0001,
        DLR_DATA = 4'b0010,
        DLR_CRC  = 4'b0100,
        DLR_DONE = 4'b1000
    } dlr_state_e;

    dlr_state_e  state_r;
    logic [8:0]  byte_cnt_r;
    logic [2:0]  ent_pos_r;
    logic [7:0]  ent_buf_r [0:3];
    logic        crc_hi_r;
    logic        ended_r;
    logic [15:0] crc;
    logic        crc_clr;
    logic        crc_en;
    logic        in_data;
    logic        last_of_entry;
    logic [39:0] entry_word;
    logic [10:0] tbl_cyl_r  [0:dlr_pkg::DLR_MAX_ENTRIES-1];
    logic [3:0]  tbl_head_r [0:dlr_pkg::DLR_MAX_ENTRIES-1];
    logic [15:0] tbl_off_r  [0:dlr_pkg::DLR_MAX_ENTRIES-1];

    // cylinder spans the first two bytes, big-endian; a single byte could not reach 1223
    // top five bits of the cylinder pair are spare and ignored
    function automatic logic [10:0] dlr_cyl_of(input logic [39:0] w);
        return w[34:24];
    endfunction

    // head number sits in the low nibble of the third byte
    function automatic logic [3:0] dlr_head_of(input logic [39:0] w);
        return w[19:16];
    endfunction

    // record only valid at sector zero of the list cylinder selected by use_backup
    assign target_ok = (cur_cyl == (use_backup ? dlr_pkg::DLR_BACKUP_CYL
                                               : dlr_pkg::DLR_PRIMARY_CYL));

    assign in_data       = (state_r == DLR_DATA) && byte_valid;
    assign last_of_entry = (ent_pos_r == dlr_pkg::DLR_ENTRY_BYTES - 3'd1);
    assign entry_word    = {ent_buf_r[0], ent_buf_r[1], ent_buf_r[2], ent_buf_r[3], byte_data};
    assign crc_clr       = sector_start;
    assign crc_en        = byte_valid && (state_r == DLR_DATA || state_r == DLR_CRC);

    dlr_crc16 u_crc (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clr     (crc_clr),
        .en      (crc_en),
        .din     (byte_data),
        .crc     (crc)
    );

    // ****************************************
    // sequencing
    // ****************************************
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r    <= DLR_IDLE;
            byte_cnt_r <= 9'h000;
            crc_hi_r   <= 1'b0;
        end else if (sector_start) begin
            state_r    <= target_ok ? DLR_DATA : DLR_IDLE;
            byte_cnt_r <= 9'h000;
            crc_hi_r   <= 1'b0;
        end else begin
            case (state_r)
                DLR_IDLE: state_r <= DLR_IDLE;
                DLR_DATA: begin
                    if (byte_valid) begin
                        byte_cnt_r <= byte_cnt_r + 9'h001;
                        if (byte_cnt_r == dlr_pkg::DLR_FIELD_BYTES - 9'h001) begin
                            state_r <= DLR_CRC;
                        end
                    end
                end
                DLR_CRC: begin
                    if (byte_valid) begin
                        crc_hi_r <= 1'b1;
                        if (crc_hi_r) begin
                            state_r <= DLR_DONE;
                        end
                    end
                end
                DLR_DONE: state_r <= DLR_DONE;
                default:  state_r <= DLR_IDLE;
            endcase
        end
    end

    // ****************************************
    // entry assembly
    // ****************************************
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ent_pos_r <= 3'h0;
        end else if (sector_start) begin
            ent_pos_r <= 3'h0;
        end else if (in_data) begin
            ent_pos_r <= last_of_entry ? 3'h0 : ent_pos_r + 3'h1;
        end
    end

    // bytes of a partial entry cut by the field end are dropped
    generate
        for (genvar g = 0; g < 4; g++) begin : g_buf
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    ent_buf_r[g] <= 8'h00;
                end else if (in_data && ent_pos_r == 3'(g)) begin
                    ent_buf_r[g] <= byte_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            entry_valid  <= 1'b0;
            entry_cyl    <= 11'h000;
            entry_head   <= 4'h0;
            entry_offset <= 16'h0000;
            entry_lo     <= 16'h0000;
            entry_hi     <= 16'h0000;
            entry_bad    <= 1'b0;
            ended_r      <= 1'b0;
            list_end     <= 1'b0;
            entry_count  <= 6'h00;
            overflow     <= 1'b0;
        end else if (sector_start) begin
            entry_valid <= 1'b0;
            ended_r     <= 1'b0;
            list_end    <= 1'b0;
            entry_count <= 6'h00;
            overflow    <= 1'b0;
        end else begin
            entry_valid <= 1'b0;
            list_end    <= 1'b0;
            if (in_data && last_of_entry && !ended_r) begin
                if (entry_word == {5{dlr_pkg::DLR_END_BYTE}}) begin
                    ended_r  <= 1'b1;
                    list_end <= 1'b1;
                end else begin
                    entry_valid  <= 1'b1;
                    entry_cyl    <= dlr_cyl_of(entry_word);
                    entry_head   <= dlr_head_of(entry_word);
                    entry_offset <= entry_word[15:0];
                    entry_lo     <= entry_word[15:0] - dlr_pkg::DLR_OFFSET_SLACK;
                    entry_hi     <= entry_word[15:0] + dlr_pkg::DLR_OFFSET_SLACK;
                    // foreign surface or cylinder zero marks a corrupt entry
                    entry_bad    <= (dlr_head_of(entry_word) != cur_head)
                                 || (dlr_cyl_of(entry_word) == 11'h000);
                    if (entry_count < dlr_pkg::DLR_MAX_IDX) begin
                        entry_count <= entry_count + 6'h01;
                    end else begin
                        overflow <= 1'b1;
                    end
                end
            end else if (in_data && byte_cnt_r == dlr_pkg::DLR_FIELD_BYTES - 9'h001
                         && !ended_r) begin
                ended_r  <= 1'b1;
                list_end <= 1'b1;
            end
        end
    end

    // ****************************************
    // entry table, fifty per surface
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (in_data && last_of_entry && !ended_r && entry_count < dlr_pkg::DLR_MAX_IDX
            && entry_word != {5{dlr_pkg::DLR_END_BYTE}}) begin
            tbl_cyl_r[entry_count]  <= dlr_cyl_of(entry_word);
            tbl_head_r[entry_count] <= dlr_head_of(entry_word);
            tbl_off_r[entry_count]  <= entry_word[15:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_cyl    <= 11'h000;
            rd_head   <= 4'h0;
            rd_offset <= 16'h0000;
        end else if (rd_idx < entry_count) begin
            rd_cyl    <= tbl_cyl_r[rd_idx];
            rd_head   <= tbl_head_r[rd_idx];
            rd_offset <= tbl_off_r[rd_idx];
        end else begin
            rd_cyl    <= 11'h000;
            rd_head   <= 4'h0;
            rd_offset <= 16'h0000;
        end
    end

    // ****************************************
    // check result: residue zero after both check bytes
    // ****************************************
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            crc_done  <= 1'b0;
            crc_error <= 1'b0;
        end else if (sector_start) begin
            crc_done  <= 1'b0;
            crc_error <= 1'b0;
        end else if (state_r == DLR_DONE && !crc_done) begin
            crc_done  <= 1'b1;
            crc_error <= (crc != 16'h0000);
        end
    end
endmodule

// ### dlr_reader_chk.sv
// dlr_reader_chk: port assertions for the defect list reader.
// assumes cur_head is held steady while a sector is walked.
`timescale 1ns/100ps
module dlr_reader_chk (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic        sector_start,
    input wire logic        byte_valid,
    input wire logic [10:0] cur_cyl,
    input wire logic [3:0]  cur_head,
    input wire logic        use_backup,
    input wire logic        target_ok,
    input wire logic        entry_valid,
    input wire logic [10:0] entry_cyl,
    input wire logic [3:0]  entry_head,
    input wire logic [15:0] entry_offset,
    input wire logic [15:0] entry_lo,
    input wire logic [15:0] entry_hi,
    input wire logic        entry_bad,
    input wire logic        list_end,
    input wire logic        crc_done,
    input wire logic        crc_error,
    input wire logic [5:0]  entry_count,
    input wire logic        overflow
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    target_sel_a: assert property (target_ok == (cur_cyl == (use_backup ?
        dlr_pkg::DLR_BACKUP_CYL : dlr_pkg::DLR_PRIMARY_CYL))) else $error("target select");
    entry_pulse_a: assert property (entry_valid |-> $past(byte_valid) ##1 !entry_valid[*4])
        else $error("entry pulse");
    end_pulse_a: assert property (list_end |=> !list_end) else $error("end pulse");
    offset_slack_a: assert property (entry_valid |-> entry_lo == entry_offset - 16'h0001
        && entry_hi == entry_offset + 16'h0001) else $error("offset slack");
    foreign_flag_a: assert property (entry_valid |-> entry_bad ==
        (entry_head != cur_head || entry_cyl == 11'h000)) else $error("bad flag");
    crc_qual_a: assert property (crc_error |-> crc_done) else $error("crc qual");
    crc_clear_a: assert property (sector_start |=> !crc_done) else $error("crc clear");
    count_cap_a: assert property (overflow |-> entry_count == 6'h32)
        else $error("count cap");
endmodule
bind dlr_reader dlr_reader_chk i_chk (.sys_clk, .arst_n, .sector_start, .byte_valid,
    .cur_cyl, .cur_head, .use_backup, .target_ok, .entry_valid, .entry_cyl, .entry_head,
    .entry_offset, .entry_lo, .entry_hi, .entry_bad, .list_end, .crc_done, .crc_error,
    .entry_count, .overflow);

// ### dlr_src.sv
// dlr_src: read channel model streaming one stored defect sector.
// assumes the bench fills rec before pulsing go.
`timescale 1ns/100ps
module dlr_src (
    input  wire logic       sys_clk,
    input  wire logic       go,
    input  wire logic       slow,
    output logic            sector_start,
    output logic            byte_valid,
    output logic      [7:0] byte_data,
    output logic            busy
);
    logic [7:0] rec [258];
    initial begin
        {sector_start, byte_valid, busy} = 3'h0;
        byte_data = 8'h00;
        forever begin
            @(posedge sys_clk);
            if (go) begin
                #1 busy = 1'b1;
                sector_start = 1'b1;
                @(posedge sys_clk);
                #1 sector_start = 1'b0;
                for (int i = 0; i < 258; i++) begin
                    byte_valid = 1'b1;
                    byte_data = rec[i];
                    @(posedge sys_clk);
                    #1;
                    if (slow) begin
                        // idle bus shows no stale byte
                        byte_valid = 1'b0;
                        byte_data = ~byte_data;
                        @(posedge sys_clk);
                        #1;
                    end
                end
                byte_valid = 1'b0;
                busy = 1'b0;
            end
        end
    end
endmodule

// ### tb.sv
// tb: self-checking bench for dlr_reader fed by dlr_src.
// assumes the checker file is compiled alongside.
`timescale 1ns/100ps
module tb;
    logic sys_clk = 1'b0, arst_n = 1'b0, go = 1'b0, slow = 1'b0, use_backup = 1'b0;
    logic [10:0] cur_cyl = 11'h000;
    logic [3:0]  cur_head = 4'h3;
    logic [5:0]  rd_idx = 6'h00;
    logic sector_start, byte_valid, busy, target_ok, entry_valid, entry_bad, list_end;
    logic crc_done, crc_error, overflow;
    logic [7:0] byte_data;
    logic [10:0] entry_cyl, rd_cyl;
    logic [3:0] entry_head, rd_head;
    logic [15:0] entry_offset, rd_offset;
    logic [5:0] entry_count;
    logic [31:0] q[$];
    int bad_count = 0, n_tests = 0, ends = 0, cyc = 0;
    always #4 sys_clk = ~sys_clk;
    dlr_src i_src (.sys_clk, .go, .slow, .sector_start, .byte_valid, .byte_data, .busy);
    dlr_reader i_dut (.sys_clk, .arst_n, .sector_start, .byte_valid, .byte_data, .cur_cyl,
        .cur_head, .use_backup, .rd_idx, .target_ok, .entry_valid, .entry_cyl, .entry_head,
        .entry_offset, .entry_lo(), .entry_hi(), .entry_bad, .list_end, .crc_done,
        .crc_error, .entry_count, .overflow, .rd_cyl, .rd_head, .rd_offset);
    always @(posedge sys_clk) begin
        if (entry_valid) q.push_back({entry_cyl, entry_head, entry_offset, entry_bad});
        if (list_end) ends++;
        cyc++;
        // ceiling well above four sectors of traffic
        if (cyc == 5000) begin
            bad_count++;
            stop_test;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic put(input int k, input logic [10:0] c, input logic [3:0] h,
                       input logic [15:0] o);
        {i_src.rec[k*5], i_src.rec[k*5+1]} = {5'h00, c};
        {i_src.rec[k*5+2], i_src.rec[k*5+3], i_src.rec[k*5+4]} = {4'h0, h, o};
    endtask
    task automatic run(input logic crc_ok);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < 256; i++) for (int b = 7; b >= 0; b--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ i_src.rec[i][b]) ? 16'h1021 : 16'h0000);
        {i_src.rec[256], i_src.rec[257]} = crc_ok ? c : ~c;
        q = {};
        ends = 0;
        @(posedge sys_clk);
        #1 go = 1'b1;
        @(posedge sys_clk);
        #1 go = 1'b0;
        for (int k = 0; k < 700 && (busy || k < 2); k++) @(posedge sys_clk);
        repeat (3) @(posedge sys_clk);
        #1;
        // a source that never finished counts against the run
        chk("busy", 32'h0, busy);
    endtask
    task automatic t_list(input logic bk, input logic ok);
        use_backup = bk;
        cur_cyl = bk ? 11'd1215 : 11'd1223;
        for (int i = 0; i < 258; i++) i_src.rec[i] = 8'h00;
        put(0, 11'd5, 4'h3, 16'h1234);
        put(1, 11'd0, 4'h3, 16'h0000);
        put(2, 11'd9, 4'h7, 16'hbeef);
        for (int i = 15; i < 20; i++) i_src.rec[i] = 8'hff;
        run(ok);
        chk("target", 32'h1, target_ok);
        chk("count", 32'h3, q.size());
        chk("e0", {11'd5, 4'h3, 16'h1234, 1'b0}, q[0]);
        chk("e1", {11'd0, 4'h3, 16'h0000, 1'b1}, q[1]);
        chk("e2", {11'd9, 4'h7, 16'hbeef, 1'b1}, q[2]);
        chk("ends", 32'h1, ends);
        chk("crc", {31'h1, !ok}, {crc_done, crc_error});
        rd_idx = 6'h02;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("rd2", {11'd9, 4'h7, 16'hbeef}, {rd_cyl, rd_head, rd_offset});
        rd_idx = 6'h05;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("rd5", 32'h0, {rd_cyl, rd_head, rd_offset});
        $display("list test done bk=%0d", bk);
    endtask
    task automatic t_foreign;
        use_backup = 1'b0;
        cur_cyl = 11'd1215;
        run(1'b1);
        chk("tgt", 32'h0, target_ok);
        chk("none", 32'h0, q.size() + ends);
        chk("idle", 32'h0, crc_done);
        $display("foreign cylinder test done");
    endtask
    task automatic t_full;
        slow = 1'b0;
        cur_cyl = 11'd1223;
        for (int k = 0; k < 51; k++) put(k, 11'(k + 1), 4'h3, 16'(k * 7));
        i_src.rec[255] = 8'hff;
        run(1'b1);
        chk("cnt", 32'h32, entry_count);
        chk("ovf", 32'h1, overflow);
        chk("eof", 32'h1, ends);
        chk("qn", 32'd51, q.size());
        chk("crc2", 32'h2, {crc_done, crc_error});
        $display("full record test done");
    endtask
    task automatic stop_test;
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        slow = 1'b1;
        t_list(1'b0, 1'b1);
        t_list(1'b1, 1'b0);
        t_foreign;
        t_full;
        stop_test;
    end
endmodule
